/* hw/peripheral_irq_enable_reg.sv */
// peripheral interrupt enable register with apb slave and request gating
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module peripheral_irq_enable_reg
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // peripheral request flags, same clock
    input  wire logic [7:0]  irq_flag_i,
    // enables and gated requests
    output logic      [7:0]  irq_enable_o,
    output logic      [7:0]  irq_request_o,
    output logic             irq_any_o
);
    logic [7:0]  enable_q;
    logic [7:0]  enable_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0]  req_q;
    logic        any_q;
    logic [7:0]  req_c;
    logic        any_c;

    function automatic logic hit(input logic [31:0] a);
        hit = (a == irq_enable_pkg::addr_byte);
    endfunction

    wire access   = psel_i && penable_i;
    wire setup    = psel_i && !penable_i;
    wire sel_hit  = hit(paddr_i);
    wire wr_fire  = access && pwrite_i && sel_hit && pstrb_i[0];

    // per-source enable fields
    wire nv_write_done_irq_en    = enable_q[irq_enable_pkg::nv_write_done_bit];
    wire comparator_irq_en       = enable_q[irq_enable_pkg::comparator_bit];
    wire serial_rx_irq_en        = enable_q[irq_enable_pkg::serial_rx_bit];
    wire serial_tx_irq_en        = enable_q[irq_enable_pkg::serial_tx_bit];
    wire capture_compare_irq_en  = enable_q[irq_enable_pkg::capture_compare_bit];
    wire timer16_overflow_irq_en = enable_q[irq_enable_pkg::timer16_bit];
    wire period_match_irq_en     = enable_q[irq_enable_pkg::period_match_bit];

    // bit 3 stays zero regardless of write data
    assign enable_d = wr_fire ? (pwdata_i[7:0] & irq_enable_pkg::enable_wmask) : enable_q;
    assign rdata_d  = (setup && !pwrite_i && sel_hit) ? {24'h000000, enable_q} : rdata_q;

    // enable register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            enable_q <= irq_enable_pkg::enable_reset;
        else
            enable_q <= enable_d;
    end

    // read data, captured in the setup phase of a read
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            rdata_q <= irq_enable_pkg::read_reset;
        else
            rdata_q <= rdata_d;
    end

    // gated requests, one cycle behind the flags
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            req_q <= irq_enable_pkg::request_reset;
            any_q <= 1'b0;
        end
        else
        begin
            req_q <= req_c;
            any_q <= any_c;
        end
    end

    // each bit gates its own source
    irq_gate i_irq_gate
    (
        .enable_i  (enable_q),
        .flag_i    (irq_flag_i),
        .request_o (req_c),
        .any_o     (any_c)
    );

    // zero wait states; unmapped access flags an error
    assign pready_o      = 1'b1;
    assign pslverr_o     = access && !sel_hit;
    assign prdata_o      = rdata_q;
    assign irq_enable_o  = enable_q;
    assign irq_request_o = req_q;
    assign irq_any_o     = any_q;

    // gating, one source per bit; a reset edge clears requests instead
    chk_nv_write_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !nv_write_done_irq_en |=> !req_q[7])
        else $error("nv write request passed while disabled");

    chk_nv_write_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && nv_write_done_irq_en && irq_flag_i[7]) |=> req_q[7])
        else $error("nv write request blocked while enabled");

    chk_comparator_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && comparator_irq_en && irq_flag_i[6]) |=> req_q[6])
        else $error("comparator request blocked while enabled");

    chk_comparator_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !comparator_irq_en |=> !req_q[6])
        else $error("comparator request passed while disabled");

    chk_serial_rx_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i |=> req_q[5] == $past(serial_rx_irq_en && irq_flag_i[5]))
        else $error("serial rx request wrong");

    chk_serial_rx_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !serial_rx_irq_en |=> !req_q[5])
        else $error("serial rx request passed while disabled");

    chk_serial_tx_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !serial_tx_irq_en |=> !req_q[4])
        else $error("serial tx request passed while disabled");

    chk_serial_tx_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && serial_tx_irq_en && irq_flag_i[4]) |=> req_q[4])
        else $error("serial tx request blocked while enabled");

    chk_capture_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && capture_compare_irq_en && irq_flag_i[2]) |=> req_q[2] && any_q)
        else $error("capture request blocked while enabled");

    chk_capture_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !capture_compare_irq_en |=> !req_q[2])
        else $error("capture request passed while disabled");

    chk_timer16_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !timer16_overflow_irq_en |=> !req_q[0])
        else $error("timer overflow request passed while disabled");

    chk_timer16_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && timer16_overflow_irq_en && irq_flag_i[0]) |=> req_q[0])
        else $error("timer overflow request blocked while enabled");

    chk_period_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && period_match_irq_en && irq_flag_i[1]) |=> req_q[1])
        else $error("period match request blocked while enabled");

    chk_period_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !period_match_irq_en |=> !req_q[1])
        else $error("period match request passed while disabled");

    chk_flag_low_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (irq_flag_i == 8'h00) |=> (req_q == 8'h00))
        else $error("request without a flag");

    chk_request_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i |=> req_q == $past(enable_q & irq_flag_i))
        else $error("gated request word wrong");

    chk_any_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i |=> any_q == $past(|(enable_q & irq_flag_i)))
        else $error("combined request wrong");

    // register access
    chk_bit3_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !enable_q[3] && !rdata_q[3])
        else $error("unimplemented bit 3 set");

    chk_bit3_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && wr_fire && pwdata_i[3]) |=> !enable_q[3])
        else $error("bit 3 took a write");

    chk_write_takes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && wr_fire) |=> enable_q == ($past(pwdata_i[7:0]) & irq_enable_pkg::enable_wmask))
        else $error("write not stored");

    chk_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && !wr_fire) |=> $stable(enable_q))
        else $error("enables changed without a write");

    chk_strobe_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && access && pwrite_i && !pstrb_i[0]) |=> $stable(enable_q))
        else $error("write without low byte strobe stored");

    chk_unmapped_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && access && pwrite_i && !sel_hit) |=> $stable(enable_q))
        else $error("unmapped write stored");

    chk_read_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && setup && !pwrite_i && sel_hit) |=> prdata_o == {24'h000000, $past(enable_q)})
        else $error("read data not captured");

    chk_read_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && !(setup && !pwrite_i && sel_hit)) |=> $stable(prdata_o))
        else $error("read data changed outside a read");

    chk_read_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        prdata_o[31:8] == 24'h000000 && !prdata_o[3])
        else $error("read data has unused bits set");

    chk_unmapped_error: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && paddr_i != irq_enable_pkg::addr_byte) |-> pslverr_o)
        else $error("unmapped access without error");

    chk_mapped_no_error: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && paddr_i == irq_enable_pkg::addr_byte) |-> !pslverr_o)
        else $error("mapped access flagged as error");

    // reset
    chk_reset_clear: assert property (@(posedge clk_i)
        !rst_n_i |=> enable_q == irq_enable_pkg::enable_reset && req_q == 8'h00 && !any_q)
        else $error("reset did not clear enables");

    chk_reset_outputs: assert property (@(posedge clk_i)
        !rst_n_i |=> prdata_o == irq_enable_pkg::read_reset && !irq_any_o)
        else $error("reset did not clear outputs");
endmodule
`default_nettype wire

/* shared/irq_enable_pkg.sv */
// constants for the peripheral interrupt enable register block
// What this block does
// - Bit 7 passes the nonvolatile write done interrupt when 1 and blocks it when 0.
// - Bit 6 passes the comparator interrupt when 1 and blocks it when 0.
// - Bit 5 passes the serial receive interrupt when 1 and blocks it when 0.
// - Bit 4 passes the serial transmit interrupt when 1 and blocks it when 0.
// - Bit 2 passes the capture/compare interrupt when 1 and blocks it when 0.
// - Bit 0 passes the 16-bit timer overflow interrupt when 1 and blocks it when 0.
// - Bit 1 passes the 8-bit timer period match interrupt when 1 and blocks it when 0.
package irq_enable_pkg;
    localparam logic [11:0] peripheral_irq_enable_1_off = 12'h08C;
    localparam logic [31:0] addr_byte = {20'h00000, peripheral_irq_enable_1_off};
    localparam logic [7:0]  enable_reset = 8'h00;
    localparam logic [7:0]  enable_wmask = 8'hF7;
    localparam logic [31:0] read_reset   = 32'h00000000;
    localparam logic [7:0]  request_reset = 8'h00;
    localparam int          nv_write_done_bit   = 7;
    localparam int          comparator_bit      = 6;
    localparam int          serial_rx_bit       = 5;
    localparam int          serial_tx_bit       = 4;
    localparam int          capture_compare_bit = 2;
    localparam int          period_match_bit    = 1;
    localparam int          timer16_bit         = 0;
    localparam int          src_count           = 8;
endpackage

/* hw/irq_gate.sv */
// per-source gating of request flags by enable bits
`timescale 1ns/1ns
`default_nettype none
module irq_gate
(
    // enables and flags
    input  wire logic [7:0] enable_i,
    input  wire logic [7:0] flag_i,
    // gated requests
    output logic      [7:0] request_o,
    output logic            any_o
);
    assign request_o = enable_i & flag_i;
    assign any_o     = |request_o;
endmodule
`default_nettype wire

/* testbench/peripheral_irq_enable_reg_test.sv */
// self-checking bench for the interrupt enable register
`timescale 1ns/1ns
`default_nettype none
module peripheral_irq_enable_reg_test;
    logic        clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [31:0] paddr_i = '0, pwdata_i = '0, prdata_o, d, r;
    logic [3:0]  pstrb_i = '0;
    logic [7:0]  irq_flag_i = '0, irq_enable_o, irq_request_o, f, en;
    logic        pready_o, pslverr_o, irq_any_o, e;
    int          err_count = 0, n_tests = 0, seed = 25359;
    always #5 clk_i = ~clk_i;
    peripheral_irq_enable_reg i_peripheral_irq_enable_reg (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_flag_i(irq_flag_i), .irq_enable_o(irq_enable_o),
        .irq_request_o(irq_request_o), .irq_any_o(irq_any_o));
    function automatic logic [7:0] exp_en(input logic [31:0] v);
        return v[7:0] & irq_enable_pkg::enable_wmask;
    endfunction
    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            $display("[ERR] %s expected %h seen %h", nm, x, g);
            err_count++;
        end
    endtask
    // one apb transfer, result left in r and e
    task automatic apb(input logic w, input logic [31:0] a, v, input logic [3:0] s);
        int k;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= v;
        pstrb_i   <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (k = 0; k < 8; k++)
        begin
            @(posedge clk_i);
            if (pready_o === 1'b1)
                break;
        end
        if (k == 8)
        begin
            $display("[ERR] pready expected 1 seen 0");
            err_count++;
            wrap_up();
        end
        else
        begin
            r = prdata_o;
            e = pslverr_o;
            psel_i    <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk("enable", 32'h0, {24'h0, irq_enable_o});
        for (int i = 0; i < 24; i++)
        begin
            d = (i == 0) ? 32'hFF : $random(seed);
            f = (i == 0) ? 8'hFF : 8'($random(seed));
            apb(1'b1, irq_enable_pkg::addr_byte, d, 4'hF);
            apb(1'b0, irq_enable_pkg::addr_byte, 32'h0, 4'hF);
            en = exp_en(d);
            chk("read", {24'h0, en}, r);
            chk("slverr", 32'h0, {31'h0, e});
            irq_flag_i <= f;
            repeat (2) @(posedge clk_i);
            #1 chk("request", {24'h0, en & f}, {24'h0, irq_request_o});
            chk("any", {31'h0, |(en & f)}, {31'h0, irq_any_o});
        end
        apb(1'b1, 32'h90, 32'hFF, 4'hF);
        chk("slverr", 32'h1, {31'h0, e});
        #1 chk("enable", {24'h0, en}, {24'h0, irq_enable_o});
        apb(1'b0, 32'h90, 32'h0, 4'hF);
        chk("slverr", 32'h1, {31'h0, e});
        chk("read", {24'h0, en}, r);
        apb(1'b1, irq_enable_pkg::addr_byte, 32'hFF, 4'h0);
        #1 chk("enable", {24'h0, en}, {24'h0, irq_enable_o});
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk("enable", 32'h0, {24'h0, irq_enable_o});
        chk("request", 32'h0, {24'h0, irq_request_o});
        chk("any", 32'h0, {31'h0, irq_any_o});
        apb(1'b1, irq_enable_pkg::addr_byte, 32'h0F, 4'h1);
        apb(1'b0, irq_enable_pkg::addr_byte, 32'h0, 4'hF);
        chk("read", {24'h0, exp_en(32'h0F)}, r);
        wrap_up();
    end
endmodule
`default_nettype wire
